// file: logic/adcc_top.sv
/*
  Converter control: AHB-Lite register slave, prescaler, trigger logic and
  conversion sequencer. Assumes the analog core returns a result word that is
  valid while the conversion cycles run, and that trigger flags are on hclk.
*/
`timescale 1ns/1ps
`include "adcc_cfg.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write strobe.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  input wire logic [6:0] trig_flags, // Trigger flags, sources 1 to 7.
  input wire logic global_irq_en, // Global interrupt enable.
  input wire logic vector_ack, // Vector executed, one-cycle pulse.
  input wire logic sleep_enter, // Processor halted in a quiet sleep.
  input wire logic [7:0] core_result, // Result from the analog core.
  input wire logic [NCH-1:0] pin_raw, // Raw pin levels.
  output logic [NCH-1:0] pin_digital, // Filtered digital inputs.
  output logic [NCH-1:0] buffer_off, // Digital buffer disable.
  output adcc_core_t core_ctl, // Drive to the analog core.
  output logic irq // Conversion-complete interrupt request.
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] mux_reg, mux_next, trg_reg, trg_next, did_reg, did_next;
  logic [7:0] csr_reg, csr_next, res_reg, res_next;
  logic [1:0] cur_ch_reg, cur_ch_next;
  logic [7:0] div_reg, div_next;
  logic [4:0] cyc_reg, cyc_next;
  logic first_reg, first_next, trg_prev_reg, trg_prev_next;
  logic [2:0] src_prev_reg, src_prev_next;
  logic [31:0] rd_reg, rd_next;
  logic [NCH-1:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
  adcc_state_t st_reg, st_next;
  logic wr, tick, trig_now, trig_sel, start_req, done;
  // High in the data phase of a control write that switches the converter on.
  logic enable_rise;
  logic [7:0] wbyte;

  // Divider mask: code 0 and 1 both give divide by 2.
  function automatic logic [7:0] div_mask(input logic [2:0] code);
    logic [2:0] c;
    c = (code == 3'd0) ? 3'd1 : code;
    div_mask = 8'((9'h001 << c) - 9'h001);
  endfunction

  // Address phase is accepted every cycle; the slave never stalls.
  assign wr = wr_pend_reg;
  assign wbyte = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_reg;
  assign enable_rise = wr && addr_reg == `ADCC_OFS_CSR && !csr_reg[`ADCC_BIT_EN] &&
                       wbyte[`ADCC_BIT_EN];

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Prescaler tick, one hclk pulse per converter clock.
  assign tick = (div_reg & div_mask(csr_reg[2:0])) == div_mask(csr_reg[2:0]);

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  // Selected trigger level; code zero follows the done flag.
  always_comb begin
    trig_sel = 1'b0;
    if (trg_reg[2:0] == 3'd0) begin
      trig_sel = csr_reg[`ADCC_BIT_IF];
    end else begin
      trig_sel = trig_flags[trg_reg[2:0] - 3'd1];
    end
  end

  // The edge is taken against last cycle's selected level, so a switch from a clear
  // source onto one that is already set counts as an edge, as software expects.
  // Rising edge; also fires on a source switch, not on switching to 0.
  assign trig_now = csr_reg[`ADCC_BIT_ATE] && trig_sel && !trg_prev_reg &&
                    !(trg_reg[2:0] == 3'd0 && src_prev_reg != 3'd0);
  assign done = (st_reg == ADCC_CONV) && tick && (cyc_reg == 5'd1);

  // ----------------------------------------------------------------
  // Start requests
  // ----------------------------------------------------------------
  // Start sources: software, auto trigger, sleep entry.
  assign start_req = (wr && addr_reg == `ADCC_OFS_CSR && wbyte[`ADCC_BIT_SC]) ||
                     trig_now || (sleep_enter && !csr_reg[`ADCC_BIT_ATE]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Next-state logic for registers and sequencer.
  always_comb begin
    wr_pend_next = hsel && hready && htrans[1] && hwrite;
    addr_next = (hsel && hready && htrans[1]) ? haddr[11:0] : addr_reg;
    mux_next = mux_reg;
    trg_next = trg_reg;
    did_next = did_reg;
    csr_next = csr_reg;
    res_next = res_reg;
    cur_ch_next = cur_ch_reg;
    div_next = 8'(div_reg + 8'h01);
    cyc_next = cyc_reg;
    first_next = first_reg;
    st_next = st_reg;
    trg_prev_next = trig_sel;
    src_prev_next = trg_reg[2:0];
    rd_next = 32'h0;
    pin_next = pin_reg;
    if (s2_reg == s3_reg) begin
      pin_next = s3_reg;
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        `ADCC_OFS_DIDR: rd_next = {24'h0, 4'h0, did_reg[3:0]};
        `ADCC_OFS_RES: rd_next = {24'h0, res_reg};
        `ADCC_OFS_MUX: rd_next = {24'h0, 6'h0, mux_reg[1:0]};
        `ADCC_OFS_TRG: rd_next = {24'h0, 5'h0, trg_reg[2:0]};
        `ADCC_OFS_CSR: rd_next = {24'h0, csr_reg};
        default: rd_next = 32'h0;
      endcase
    end
    if (wr) begin
      case (addr_reg)
        `ADCC_OFS_DIDR: did_next = {4'h0, wbyte[3:0]};
        `ADCC_OFS_MUX: mux_next = {6'h0, wbyte[1:0]};
        `ADCC_OFS_TRG: trg_next = {5'h0, wbyte[2:0]};
        `ADCC_OFS_CSR: begin
          csr_next = {wbyte[7], csr_reg[6], wbyte[5], csr_reg[4], wbyte[3:0]};
          if (wbyte[`ADCC_BIT_IF]) begin
            csr_next[`ADCC_BIT_IF] = 1'b0;
          end
          if (!csr_reg[`ADCC_BIT_EN] && wbyte[`ADCC_BIT_EN]) begin
            first_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (vector_ack) begin
      csr_next[`ADCC_BIT_IF] = 1'b0;
    end
    case (st_reg)
      ADCC_IDLE: begin
        if (start_req && csr_next[`ADCC_BIT_EN]) begin
          st_next = ADCC_CONV;
          cur_ch_next = mux_next[1:0];
          cyc_next = first_next ? `ADCC_CYC_FIRST : `ADCC_CYC_NORMAL;
          first_next = 1'b0;
          csr_next[`ADCC_BIT_SC] = 1'b1;
          div_next = 8'h00;
        end
      end
      ADCC_CONV: begin
        if (tick) begin
          cyc_next = 5'(cyc_reg - 5'd1);
        end
        if (done) begin
          res_next = core_result;
          csr_next[`ADCC_BIT_IF] = 1'b1;
          cur_ch_next = mux_reg[1:0];
          if (csr_next[`ADCC_BIT_ATE] && trg_reg[2:0] == 3'd0) begin
            cyc_next = `ADCC_CYC_NORMAL;
          end else begin
            st_next = ADCC_IDLE;
            csr_next[`ADCC_BIT_SC] = 1'b0;
          end
        end
      end
      default: st_next = ADCC_IDLE;
    endcase
    if (!csr_next[`ADCC_BIT_EN]) begin
      st_next = ADCC_IDLE;
      csr_next[`ADCC_BIT_SC] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Registers only; reset loads constants.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
      mux_reg <= `ADCC_RST_BYTE;
      trg_reg <= `ADCC_RST_BYTE;
      did_reg <= `ADCC_RST_BYTE;
      csr_reg <= `ADCC_RST_BYTE;
      res_reg <= `ADCC_RST_BYTE;
      cur_ch_reg <= 2'h0;
      div_reg <= 8'h00;
      cyc_reg <= 5'h00;
      first_reg <= 1'b0;
      st_reg <= ADCC_IDLE;
      trg_prev_reg <= 1'b0;
      src_prev_reg <= 3'h0;
      rd_reg <= 32'h0;
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      mux_reg <= mux_next;
      trg_reg <= trg_next;
      did_reg <= did_next;
      csr_reg <= csr_next;
      res_reg <= res_next;
      cur_ch_reg <= cur_ch_next;
      div_reg <= div_next;
      cyc_reg <= cyc_next;
      first_reg <= first_next;
      st_reg <= st_next;
      trg_prev_reg <= trg_prev_next;
      src_prev_reg <= src_prev_next;
      rd_reg <= rd_next;
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Disabled pins read zero; the buffer-off drive goes to the pads.
  assign pin_digital = pin_reg & ~did_reg[NCH-1:0];
  assign buffer_off = did_reg[NCH-1:0];
  assign core_ctl.channel = cur_ch_reg;
  assign core_ctl.sample = (st_reg == ADCC_CONV);
  assign core_ctl.start_core = (st_reg == ADCC_CONV) && (cyc_reg == `ADCC_CYC_FIRST);
  assign irq = csr_reg[`ADCC_BIT_IF] && csr_reg[`ADCC_BIT_IE] && global_irq_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Interrupt request and flag handling.
  irq_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == (csr_reg[4] && csr_reg[3] && global_irq_en))
    else $error("interrupt request not gated by flag and enables");
  done_sets_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    done && !vector_ack |=> csr_reg[4] && res_reg == $past(core_result))
    else $error("completion did not set flag with result");
  flag_rise_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(csr_reg[4]) |-> $past(done))
    else $error("flag rose without a completion");
  vec_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    vector_ack && !done |=> !csr_reg[4])
    else $error("vector did not clear flag");
  write_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr && addr_reg == `ADCC_OFS_CSR && wbyte[4] && !done |=> !csr_reg[4])
    else $error("written one did not clear flag");
  // A completion in the same cycle as a clear must not be lost.
  set_wins_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    done && (vector_ack || (wr && addr_reg == `ADCC_OFS_CSR && wbyte[4])) |=> csr_reg[4])
    else $error("clear beat a completion");

  // Enable, start bit and sequencer.
  off_abort_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !csr_reg[7] |-> st_reg == ADCC_IDLE && !csr_reg[6])
    else $error("conversion runs while disabled");
  busy_bit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    csr_reg[6] == (st_reg == ADCC_CONV))
    else $error("start bit does not follow busy state");
  sc_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr && addr_reg == `ADCC_OFS_CSR && !wbyte[6] && st_reg == ADCC_IDLE && !trig_now &&
    !sleep_enter |=> !csr_reg[6])
    else $error("writing zero to start bit started a conversion");
  start_go_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_IDLE && start_req && csr_next[7] |=> st_reg == ADCC_CONV && csr_reg[6])
    else $error("start request did not begin a conversion");
  single_end_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    done && !(csr_next[5] && trg_reg[2:0] == 3'd0) |=> st_reg == ADCC_IDLE && !csr_reg[6])
    else $error("single conversion did not stop");
  free_restart_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    done && csr_next[5] && csr_next[7] && trg_reg[2:0] == 3'd0 |=>
    st_reg == ADCC_CONV && cyc_reg == `ADCC_CYC_NORMAL)
    else $error("free running did not restart");
  sleep_start_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sleep_enter && st_reg == ADCC_IDLE && !csr_reg[5] && csr_next[7] |=> st_reg == ADCC_CONV)
    else $error("sleep entry did not start a conversion");
  enable_first_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    enable_rise |=> first_reg || st_reg == ADCC_CONV)
    else $error("enable did not arm the long first conversion");

  // Conversion length and prescaler.
  len_limit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_CONV |-> cyc_reg <= 5'd25 && cyc_reg != 5'd0)
    else $error("conversion cycle count out of range");
  first_len_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_IDLE && st_next == ADCC_CONV && (first_reg || enable_rise) |=>
    cyc_reg == `ADCC_CYC_FIRST)
    else $error("first conversion not given the long count");
  later_len_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_IDLE && st_next == ADCC_CONV && !first_reg && !enable_rise |=>
    cyc_reg == `ADCC_CYC_NORMAL)
    else $error("later conversion not given the normal count");
  cyc_step_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_CONV && tick && !done |=> cyc_reg == 5'($past(cyc_reg) - 5'd1))
    else $error("cycle count did not step on a converter tick");
  cyc_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_CONV && !tick |=> cyc_reg == $past(cyc_reg))
    else $error("cycle count moved between converter ticks");
  tick_gap_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick |=> !tick)
    else $error("converter clock faster than half the system clock");
  tick_odd_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick |-> div_reg[0])
    else $error("converter tick off the divider phase");

  // Channel, result and disabled pins.
  chan_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_CONV && !$past(done) && $past(st_reg) == ADCC_CONV |-> $stable(cur_ch_reg))
    else $error("channel changed mid conversion");
  chan_latch_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg == ADCC_IDLE && st_next == ADCC_CONV |=> cur_ch_reg == $past(mux_next[1:0]))
    else $error("channel not latched at start");
  res_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !done |=> res_reg == $past(res_reg))
    else $error("result changed without a completion");
  pin_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pin_digital & did_reg[NCH-1:0]) == '0)
    else $error("disabled pin reads one");

  // Trigger logic.
  no_auto_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !csr_reg[5] |-> !trig_now)
    else $error("trigger fired without auto trigger");
  trig_edge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    csr_reg[5] && trig_sel && !trg_prev_reg && trg_reg[2:0] != 3'd0 |-> trig_now)
    else $error("rising trigger edge was missed");
  free_quiet_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trg_reg[2:0] == 3'd0 && $past(trg_reg[2:0]) != 3'd0 |-> !trig_now)
    else $error("switching to free running made a trigger");
endmodule

// file: inc/adcc_cfg.svh
/*
  Offsets, field positions, reset values and timing counts for the converter
  control block. Registers are numbered by index; each takes one aligned
  AHB-Lite word, so its byte address is four times its index, at base zero.
*/
// Function
// - Channel code 00..11 routes input 0..3.
// - Channel change waits for running conversion's end.
// - Enable bit seven; clearing aborts conversion.
// - Single mode: each start begins one conversion.
// - Free running: start begins first conversion.
// - First conversion 25 cycles, later 13.
// - Start reads one while busy; zero ignored.
// - Auto trigger starts on selected rising edge.
// - Done flag sets when result updated.
// - Flag clears on vector or written one.
// - Interrupt request needs flag, enable, global enable.
// - Prescaler divides by 2,2,4..128.
// - Trigger source ignored without auto trigger.
// - Trigger codes select eight listed sources.
// - Switching clear-to-set source makes rising edge.
// - Selecting free running creates no trigger.
// - Result register read-only, last conversion.
// - Disable bit forces pin digital input zero.
// - Result code scales linearly, 00 to ff.
// - Sleep entry starts conversion when idle single.
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_IDX_DIDR 10'h017
`define ADCC_IDX_RES 10'h019
`define ADCC_IDX_MUX 10'h01b
`define ADCC_IDX_TRG 10'h01c
`define ADCC_IDX_CSR 10'h01d
`define ADCC_IDX_TO_ADDR(i) ({(i), 2'b00})
`define ADCC_OFS_DIDR `ADCC_IDX_TO_ADDR(`ADCC_IDX_DIDR)
`define ADCC_OFS_RES `ADCC_IDX_TO_ADDR(`ADCC_IDX_RES)
`define ADCC_OFS_MUX `ADCC_IDX_TO_ADDR(`ADCC_IDX_MUX)
`define ADCC_OFS_TRG `ADCC_IDX_TO_ADDR(`ADCC_IDX_TRG)
`define ADCC_OFS_CSR `ADCC_IDX_TO_ADDR(`ADCC_IDX_CSR)
`define ADCC_BIT_EN 7
`define ADCC_BIT_SC 6
`define ADCC_BIT_ATE 5
`define ADCC_BIT_IF 4
`define ADCC_BIT_IE 3
`define ADCC_RST_BYTE 8'h00
`define ADCC_CYC_FIRST 5'd25
`define ADCC_CYC_NORMAL 5'd13
`endif

// file: inc/adcc_pkg.sv
/*
  Types shared by the converter control block.
  Assumes the cfg header supplies all numbers.
*/
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONV} adcc_state_t;
  typedef struct packed {
    logic [1:0] channel;
    logic sample;
    logic start_core;
  } adcc_core_t;
endpackage

// file: testbench/adcc_core_model.sv
/*
  Behavioural analog core with its input mux.
  Assumes core_ctl comes from the control block and vin from the bench.
*/
`timescale 1ns/1ps
module adcc_core_model
  import adcc_pkg::*;
(
  input wire adcc_core_t core_ctl, // Control from the block.
  input wire logic [7:0] vin [4], // Input levels as ideal codes.
  output logic [7:0] core_result // Code handed back.
);
  logic [7:0] last;
  logic live;
  // Outside a conversion the code is inverted, so a late sample reads wrong.
  always_comb begin
    live = core_ctl.sample | core_ctl.start_core;
    core_result = live ? vin[core_ctl.channel] : ~last;
  end
  // Remember the last code that was shown.
  always_latch begin
    if (live) begin
      last <= vin[core_ctl.channel];
    end
  end
endmodule

// file: testbench/adc_conversion_control_tb.sv
/*
  Self-checking bench: AHB-Lite master, read monitor and tests.
  Assumes the package, the design and the core model compile first.
*/
`timescale 1ns/1ps
module adc_conversion_control_tb
  import adcc_pkg::*;
;
  logic hclk, hresetn = 0, hsel = 0, hwrite = 0, gie = 1, vack = 0, slp = 0, rd_dp = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'b010;
  logic [6:0] trig = 0;
  logic [3:0] pin_raw = 0, pin_dig, buf_off;
  logic [7:0] core_result, d, vin [4], q [$];
  logic irq, hreadyout, hresp;
  adcc_core_t core_ctl;
  integer seed = 32'hbc75;
  int fail_count, checked, n, k;
  localparam logic [7:0] EN = 8'h80, SC = 8'h40, AT = 8'h20, IF = 8'h10, IE = 8'h08;

  adcc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_flags(trig),
    .global_irq_en(gie), .vector_ack(vack), .sleep_enter(slp), .core_result(core_result),
    .pin_raw(pin_raw), .pin_digital(pin_dig), .buffer_off(buf_off), .core_ctl(core_ctl),
    .irq(irq));
  adcc_core_model i_core (.core_ctl(core_ctl), .vin(vin), .core_result(core_result));

  // 100 MHz system clock.
  initial begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single word transfer; a read notes its expected byte in the queue.
  task automatic bus(logic [7:0] a, logic w, logic [7:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, a, 2'b00}; // Register index times four.
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, e};
    rd_dp <= !w;
    if (!w) q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  // Read data is taken at the edge that closes the data phase.
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      chk("hrdata", {24'h0, q.pop_front()}, hrdata);
    end
  end

  // Waits for the request; too early or too late both count as wrong.
  task automatic wirq(int lo, int hi);
    n = 0;
    // Let the last write settle, so a flag it clears is not seen as set.
    @(negedge hclk);
    while (irq !== 1'b1 && n < hi) begin
      @(negedge hclk);
      n++;
    end
    chk("irq", 1, irq);
    chk("not early", 1, n >= lo);
  endtask

  task automatic clr(logic [7:0] c);
    bus(8'h1d, 1, c | IF);
    @(negedge hclk);
    chk("irq cleared", 0, irq);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run time.
  initial begin
    #300000;
    fail_count++;
    conclude();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) vin[i] = 8'($random(seed));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (vin[i]) bus(8'h17 + 8'(2 * i), 0, 8'h00);
    bus(8'h1c, 0, 8'h00);
    bus(8'h18, 0, 8'h00);
    $display("test reset finished");
    d = 8'($random(seed)) & 8'h0f;
    pin_raw <= 4'($random(seed));
    bus(8'h17, 1, d);
    bus(8'h17, 0, d);
    repeat (4) @(negedge hclk);
    chk("buffer_off", d, buf_off);
    chk("pin_digital", pin_raw & ~d[3:0], pin_dig);
    $display("test pins finished");
    for (int c = 0; c < 4; c++) begin
      bus(8'h1b, 1, 8'(c));
      bus(8'h1d, 1, EN | IE | SC);
      wirq(c == 0 ? 48 : 24, c == 0 ? 58 : 34);
      bus(8'h19, 0, vin[c]);
      clr(EN | IE);
    end
    for (int p = 0; p < 8; p++) begin
      k = (p < 2) ? 26 : 13 << p;
      bus(8'h1d, 1, EN | IE | SC | 8'(p));
      wirq(k - 2, k + k / 13 + 6);
      clr(EN | IE | 8'(p));
    end
    $display("test timing finished");
    bus(8'h1b, 1, 8'h01);
    bus(8'h1d, 1, EN | IE | SC);
    bus(8'h1b, 1, 8'h02);
    bus(8'h1d, 0, EN | IE | SC);
    wirq(14, 34);
    bus(8'h19, 1, 8'h5a);
    bus(8'h19, 0, vin[1]);
    bus(8'h1d, 1, EN | IE);
    bus(8'h1d, 0, EN | IE | IF);
    vack <= 1'b1;
    @(posedge hclk);
    vack <= 1'b0;
    bus(8'h1d, 0, EN | IE);
    gie <= 1'b0;
    bus(8'h1d, 1, EN | IE | SC);
    repeat (40) @(negedge hclk);
    chk("irq masked", 0, irq);
    gie <= 1'b1;
    wirq(0, 2);
    clr(EN | IE);
    bus(8'h1d, 1, EN | IE | SC);
    bus(8'h1d, 1, 8'h00);
    repeat (40) @(negedge hclk);
    bus(8'h1d, 0, 8'h00);
    $display("test control finished");
    bus(8'h1d, 1, EN | IE);
    bus(8'h1c, 1, 8'h01);
    trig <= 7'h01;
    bus(8'h1d, 0, EN | IE);
    for (int t = 1; t < 8; t++) begin
      trig <= 7'h00;
      bus(8'h1c, 1, 8'(t));
      bus(8'h1d, 1, EN | IE | AT);
      trig <= 7'(1 << (t - 1));
      wirq(0, 60);
      clr(EN | IE);
    end
    bus(8'h1c, 1, 8'h01);
    trig <= 7'h02;
    bus(8'h1d, 1, EN | IE | AT);
    bus(8'h1c, 1, 8'h02);
    wirq(0, 34);
    bus(8'h1c, 1, 8'h00);
    bus(8'h1d, 0, EN | IE | AT | IF);
    bus(8'h1d, 1, EN | IE | AT | SC | IF);
    wirq(24, 34);
    bus(8'h1d, 1, EN | IE | AT | IF);
    wirq(10, 34);
    clr(8'h00);
    $display("test trigger finished");
    bus(8'h1d, 1, EN | IE);
    slp <= 1'b1;
    @(posedge hclk);
    slp <= 1'b0;
    wirq(0, 60);
    $display("test sleep finished");
    conclude();
  end
endmodule
